// File: inc/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_PIN_SEL = 8'h00;
   localparam logic [7:0] OFF_CAUSE = 8'h04;
   localparam logic [7:0] OFF_BO_LEVEL = 8'h08;
   localparam logic [7:0] OFF_WDT_EN = 8'h0c;
   localparam logic [7:0] OFF_FLASH_CMD = 8'h10;
   localparam logic [7:0] OFF_CTRL = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_FAULT_DLY = 8'h1c;
   localparam logic [7:0] OFF_FILT_DLY = 8'h20;
   localparam logic [7:0] OFF_REL_DLY = 8'h24;
   // Pin function codes
   localparam logic [7:0] PIN_GPIO = 8'h55;
   localparam logic [7:0] PIN_RESET = 8'haa;
   localparam logic [7:0] PIN_SEL_POR = 8'h55;
   // Brownout level codes
   localparam logic [7:0] BO_1V7 = 8'h66;
   localparam logic [7:0] BO_1V9 = 8'h55;
   localparam logic [7:0] BO_2V55 = 8'h33;
   localparam logic [7:0] BO_3V15 = 8'h99;
   localparam logic [7:0] BO_3V8 = 8'haa;
   localparam logic [7:0] BO_OFF = 8'hf0;
   localparam logic [7:0] BO_LEVEL_POR = 8'h66;
   // Watchdog enable field codes
   localparam logic [4:0] WDT_OFF = 5'h15;
   localparam logic [4:0] WDT_ON = 5'h0a;
   localparam logic [4:0] WDT_EN_POR = 5'h0a;
   // Flash command that resets the device
   localparam logic [7:0] FLASH_RST_CMD = 8'h55;
   // Cause flag bit positions
   localparam int CF_SEL = 3;
   localparam int CF_BO_EVT = 2;
   localparam int CF_BO_SET = 1;
   localparam int CF_WDT = 0;
   // Control bit positions
   localparam int CT_SLEEP = 0;
   localparam int CT_IDLE = 1;
   // Timing (ns) and cycle counts at 100 MHz
   localparam int CLK_NS = 10;
   localparam int FAULT_DLY_NS = 160;
   localparam int FILT_DLY_NS = 120;
   localparam int REL_DLY_NS = 200;
   localparam logic [15:0] FAULT_DLY_CYC =
      16'((FAULT_DLY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] FILT_DLY_CYC =
      16'((FILT_DLY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] REL_DLY_CYC =
      16'((REL_DLY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RST_PULSE_CYC = 16'h0004;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_FAULT_WAIT = 2'b01,
      ST_RESET = 2'b10,
      ST_RELEASE = 2'b11
   } rsc_state_e;
endpackage
`default_nettype wire

// File: logic/rsc_reset_ctrl.sv
// What this block does
// - Pin select 0x55 makes shared pin general I/O, 0xaa makes it reset input.
// - Any other pin select code resets the device after fault delay.
// - Pin select loads 0x55 at power-on.
// - With reset function selected, other alternate functions on pin ignored.
// - Cause bit 3 sets on pin select corruption reset; software 0 clears.
// - Cause bits 7 to 4 read zero.
// - Cause bit 2 sets on qualified brownout reset; software 0 clears.
// - Cause bit 1 sets on undefined brownout level; software 0 clears.
// - Brownout level codes pick five thresholds; 0xf0 disables brownout reset.
// - Undefined level code resets after fault delay and restores 0x66.
// - Low supply resets only when longer than filter time.
// - Qualified brownout reset keeps brownout level register.
// - Brownout detection suppressed in sleep or idle.
// - Brownout level loads 0x66 at power-on.
// - Writing 0x55 to flash command register resets the device.
// - Power-on presets port data and direction high; execution from zero.
// - Low external reset input resets device and clears program counter.
// - After reset input returns high, wait pin release delay.
// - Pin reset leaves some registers unchanged, unlike power-on.
// - Cause bit 0 sets on watchdog enable corruption reset; software 0 clears.
`default_nettype none
module rsc_reset_ctrl
   import rsc_pkg::*;
(
   // Clock and power-on reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared pin and supply comparator
   input wire logic shared_io_pin_in,
   input wire logic supply_below_in,
   input wire logic alt_func_req,
   // Device reset and pin routing
   output logic device_reset_n,
   output logic por_reset_n,
   output logic pin_is_reset,
   output logic alt_func_en,
   output logic gpio_pin_in
);
   import rsc_pkg::*;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic pin_meta_reg, pin_sync_reg;
   logic sup_meta_reg, sup_sync_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
         sup_meta_reg <= 1'b0;
         sup_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= shared_io_pin_in;
         pin_sync_reg <= pin_meta_reg;
         sup_meta_reg <= supply_below_in;
         sup_sync_reg <= sup_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] pin_sel_reg;
   logic [7:0] bo_level_reg;
   logic [4:0] wdt_en_reg;
   logic [3:0] cause_reg;
   logic [1:0] ctrl_reg;
   logic [15:0] fault_dly_reg, filt_dly_reg, rel_dly_reg;
   rsc_state_e state_reg, state_next;
   logic [15:0] cnt_reg;
   logic [15:0] filt_cnt_reg;
   logic [2:0] pend_reg;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire pin_sel_ok = (pin_sel_reg == PIN_GPIO) ||
      (pin_sel_reg == PIN_RESET);
   wire pin_reset_sel = (pin_sel_reg == PIN_RESET);
   wire bo_level_ok = (bo_level_reg == BO_1V7) ||
      (bo_level_reg == BO_1V9) || (bo_level_reg == BO_2V55) ||
      (bo_level_reg == BO_3V15) || (bo_level_reg == BO_3V8) ||
      (bo_level_reg == BO_OFF);
   wire wdt_en_ok = (wdt_en_reg == WDT_OFF) || (wdt_en_reg == WDT_ON);
   wire low_power = ctrl_reg[CT_SLEEP] || ctrl_reg[CT_IDLE];
   wire bo_armed = bo_level_ok && (bo_level_reg != BO_OFF) &&
      !low_power;
   wire bo_low = bo_armed && sup_sync_reg;
   wire bo_qualified = bo_low && (filt_cnt_reg >= filt_dly_reg);
   wire ext_low = pin_reset_sel && !pin_sync_reg;
   wire cfg_fault = !pin_sel_ok || !bo_level_ok || !wdt_en_ok;
   wire in_run = (state_reg == ST_RUN);

   // AXI write handshake
   logic aw_have_reg, w_have_reg, bvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg, wready_reg, arready_reg;
   wire aw_take = s_axi_awvalid && awready_reg;
   wire w_take = s_axi_wvalid && wready_reg;
   wire wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
   wire aw_have_nx = !wr_go && (aw_take || aw_have_reg);
   wire w_have_nx = !wr_go && (w_take || w_have_reg);
   wire bvalid_nx = wr_go || (bvalid_reg && !s_axi_bready);
   wire wr_lane0 = wr_go && w_strb_reg[0];
   wire [7:0] wb = w_data_reg[7:0];
   wire wr_known = (aw_addr_reg <= OFF_REL_DLY) &&
      (aw_addr_reg[1:0] == 2'b00);
   wire wr_pin = wr_lane0 && (aw_addr_reg == OFF_PIN_SEL);
   wire wr_cause = wr_lane0 && (aw_addr_reg == OFF_CAUSE);
   wire wr_bo = wr_lane0 && (aw_addr_reg == OFF_BO_LEVEL);
   wire wr_wdt = wr_lane0 && (aw_addr_reg == OFF_WDT_EN);
   wire wr_flash = wr_lane0 && (aw_addr_reg == OFF_FLASH_CMD);
   wire wr_ctrl = wr_lane0 && (aw_addr_reg == OFF_CTRL);
   wire wr_fd = wr_go && (aw_addr_reg == OFF_FAULT_DLY);
   wire wr_fl = wr_go && (aw_addr_reg == OFF_FILT_DLY);
   wire wr_rl = wr_go && (aw_addr_reg == OFF_REL_DLY);
   wire flash_reset = wr_flash && (wb == FLASH_RST_CMD);

   // Merged 16-bit write with byte lanes
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   // Pending config faults: pin, level, watchdog
   wire fault_done = (state_reg == ST_FAULT_WAIT) &&
      (cnt_reg >= fault_dly_reg);
   wire hard_trig = bo_qualified || flash_reset || ext_low;
   wire dev_run_next = (state_next == ST_RUN) ||
      (state_next == ST_FAULT_WAIT);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (hard_trig)
               state_next = ST_RESET;
            else if (cfg_fault)
               state_next = ST_FAULT_WAIT;
         end
         ST_FAULT_WAIT: begin
            if (hard_trig || fault_done)
               state_next = ST_RESET;
         end
         ST_RESET: begin
            if (!ext_low && (cnt_reg >= RST_PULSE_CYC - 16'h0001))
               state_next = ST_RELEASE;
         end
         ST_RELEASE: begin
            if (ext_low)
               state_next = ST_RESET;
            else if (cnt_reg >= rel_dly_reg)
               state_next = ST_RUN;
         end
         default: state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_RUN;
         cnt_reg <= 16'h0000;
         filt_cnt_reg <= 16'h0000;
         pend_reg <= 3'b000;
         device_reset_n <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? 16'h0000
            : cnt_reg + 16'h0001;
         filt_cnt_reg <= (bo_low && in_run) ?
            filt_cnt_reg + 16'h0001 : 16'h0000;
         if (state_reg == ST_RUN && cfg_fault)
            pend_reg <= {!pin_sel_ok, !bo_level_ok, !wdt_en_ok};
         else if (state_reg == ST_RELEASE)
            pend_reg <= 3'b000;
         device_reset_n <= dev_run_next;
      end
   end

   // ------------------------------------------------------------
   // Register writes and cause flags
   // ------------------------------------------------------------
   wire entering_rst = (state_next == ST_RESET) &&
      (state_reg != ST_RESET);
   wire sel_evt = entering_rst && (state_reg == ST_FAULT_WAIT) &&
      fault_done && pend_reg[2];
   wire bo_set_evt = entering_rst && (state_reg == ST_FAULT_WAIT) &&
      fault_done && pend_reg[1];
   wire wdt_evt = entering_rst && (state_reg == ST_FAULT_WAIT) &&
      fault_done && pend_reg[0];
   wire bo_evt = entering_rst && bo_qualified;
   wire [3:0] cause_set = {sel_evt, bo_evt, bo_set_evt, wdt_evt};
   wire [3:0] cause_clr = wr_cause ? ~wb[3:0] : 4'h0;
   // Pin resets clear ctrl; brownout keeps it; level restored only on fault
   wire pin_rst_evt = entering_rst && ext_low;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sel_reg <= PIN_SEL_POR;
         bo_level_reg <= BO_LEVEL_POR;
         wdt_en_reg <= WDT_EN_POR;
         cause_reg <= 4'h0;
         ctrl_reg <= 2'b00;
         fault_dly_reg <= FAULT_DLY_CYC;
         filt_dly_reg <= FILT_DLY_CYC;
         rel_dly_reg <= REL_DLY_CYC;
         por_reset_n <= 1'b0;
      end else begin
         por_reset_n <= 1'b1;
         // Set wins over software clear
         cause_reg <= (cause_reg & ~cause_clr) | cause_set;
         if (bo_set_evt)
            bo_level_reg <= BO_LEVEL_POR;
         else if (wr_bo)
            bo_level_reg <= wb;
         if (pin_rst_evt || (entering_rst && !bo_qualified &&
               !pend_reg[2] && pin_sel_ok))
            ctrl_reg <= 2'b00;
         else if (wr_ctrl)
            ctrl_reg <= wb[1:0];
         if (sel_evt || wdt_evt)
            pin_sel_reg <= PIN_SEL_POR;
         else if (wr_pin)
            pin_sel_reg <= wb;
         if (wdt_evt || sel_evt)
            wdt_en_reg <= WDT_EN_POR;
         else if (wr_wdt)
            wdt_en_reg <= wb[7:3];
         if (wr_fd)
            fault_dly_reg <= merge16(fault_dly_reg, w_data_reg, w_strb_reg);
         if (wr_fl)
            filt_dly_reg <= merge16(filt_dly_reg, w_data_reg, w_strb_reg);
         if (wr_rl)
            rel_dly_reg <= merge16(rel_dly_reg, w_data_reg, w_strb_reg);
      end
   end

   // ------------------------------------------------------------
   // Pin routing
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_is_reset <= 1'b0;
         alt_func_en <= 1'b0;
         gpio_pin_in <= 1'b1;
      end else begin
         pin_is_reset <= pin_reset_sel;
         alt_func_en <= alt_func_req && !pin_reset_sel;
         gpio_pin_in <= pin_reset_sel ? 1'b1 : pin_sync_reg;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic [1:0] bresp_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_known && aw_addr_reg != OFF_STATUS) ?
               RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Read path
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rd_mux;
   logic rd_err;
   wire ar_take = s_axi_arvalid && arready_reg;
   wire rvalid_nx = ar_take || (rvalid_reg && !s_axi_rready);
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (s_axi_araddr)
         OFF_PIN_SEL: rd_mux = {24'h0, pin_sel_reg};
         OFF_CAUSE: rd_mux = {28'h0, cause_reg};
         OFF_BO_LEVEL: rd_mux = {24'h0, bo_level_reg};
         OFF_WDT_EN: rd_mux = {24'h0, wdt_en_reg, 3'b000};
         OFF_FLASH_CMD: rd_mux = 32'h0000_0000;
         OFF_CTRL: rd_mux = {30'h0, ctrl_reg};
         OFF_STATUS: rd_mux = {27'h0, pin_sync_reg, sup_sync_reg,
            pin_reset_sel, state_reg};
         OFF_FAULT_DLY: rd_mux = {16'h0, fault_dly_reg};
         OFF_FILT_DLY: rd_mux = {16'h0, filt_dly_reg};
         OFF_REL_DLY: rd_mux = {16'h0, rel_dly_reg};
         default: rd_err = 1'b1;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   // Registered ready outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
      end else begin
         awready_reg <= !aw_have_nx && !bvalid_nx;
         wready_reg <= !w_have_nx && !bvalid_nx;
         arready_reg <= !rvalid_nx;
      end
   end
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule
`default_nettype wire

// File: test/rsc_reset_ctrl_sva.sv
`default_nettype none
module rsc_reset_ctrl_chk
   import rsc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // Reset and pin outputs
   input wire logic device_reset_n,
   input wire logic por_reset_n,
   input wire logic pin_is_reset,
   input wire logic alt_func_en,
   input wire logic gpio_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Helpers
   // ----
   logic [7:0] rd_addr;
   wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   always_ff @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // Properties
   // ----
   property p_por;
      $rose(aresetn) |-> !por_reset_n ##1 (por_reset_n && device_reset_n);
   endproperty
   a_por: assert property (p_por) else $error("por release wrong");
   property p_alt_gate;
      pin_is_reset && $past(pin_is_reset) |-> !alt_func_en;
   endproperty
   a_alt_gate: assert property (p_alt_gate) else $error("alt not gated");
   property p_gpio_rst;
      pin_is_reset && $past(pin_is_reset) |-> gpio_pin_in;
   endproperty
   a_gpio_rst: assert property (p_gpio_rst) else $error("gpio not 1");
   property p_cause_hi;
      s_axi_rvalid && rd_addr == OFF_CAUSE |-> s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_cause_hi: assert property (p_cause_hi) else $error("cause high");
   property p_flash;
      aw_w && s_axi_awaddr == OFF_FLASH_CMD && s_axi_wstrb[0] &&
         s_axi_wdata[7:0] == FLASH_RST_CMD |-> ##[1:4] !device_reset_n;
   endproperty
   a_flash: assert property (p_flash) else $error("no flash reset");
   property p_pulse;
      $fell(device_reset_n) |-> !device_reset_n [*4];
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset too short");
   property p_bresp;
      aw_w |-> ##2 s_axi_bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("late bvalid");
   property p_bblock;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_bblock: assert property (p_bblock) else $error("ready with b");
   property p_rresp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rresp: assert property (p_rresp) else $error("late rvalid");
   property p_unmap;
      s_axi_rvalid && rd_addr > OFF_REL_DLY |->
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   c_fault: cover property ($fell(device_reset_n));
   c_pin: cover property (pin_is_reset && !device_reset_n);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_chk u_chk (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .device_reset_n, .por_reset_n,
   .pin_is_reset, .alt_func_en, .gpio_pin_in);
`default_nettype wire

// File: test/rsc_far_model.sv
`default_nettype none
module rsc_far_model (
   // Clock
   input wire logic aclk,
   // Bench controls
   input wire logic pin_pull_low,
   input wire logic supply_low,
   // Towards the block
   output logic shared_io_pin_in,
   output logic supply_below_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // Power-on hold, pull-up otherwise
   // ----
   int hold_cnt = 6;
   always @(posedge aclk)
      if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   assign shared_io_pin_in = !(pin_pull_low || hold_cnt > 0);
   assign supply_below_in = supply_low;
endmodule
`default_nettype wire

// File: test/tb_top.sv
`default_nettype none
module tb_top
   import rsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, alt_func_req = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, device_reset_n, por_reset_n, pin_is_reset;
   logic alt_func_en, gpio_pin_in, pin_low = 0, sup_low = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   wire shared_io_pin_in, supply_below_in;
   int err_count = 0, compares = 0, n;
   logic [7:0] codes [6] = '{BO_1V7, BO_1V9, BO_2V55, BO_3V15, BO_3V8, BO_OFF};
   rsc_reset_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shared_io_pin_in,
      .supply_below_in, .alt_func_req, .device_reset_n, .por_reset_n,
      .pin_is_reset, .alt_func_en, .gpio_pin_in);
   rsc_far_model far (.aclk, .pin_pull_low(pin_low), .supply_low(sup_low),
      .shared_io_pin_in, .supply_below_in);
   initial begin
      forever #5 aclk = ~aclk;
   end
   // ----
   // Tasks
   // ----
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      int k = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      chk("bvalid", 1, s_axi_bvalid);
   endtask
   task automatic rd(logic [7:0] a);
      int k = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 200);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk("rvalid", 1, s_axi_rvalid);
   endtask
   task automatic wait_rst(logic lvl, int mx);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (device_reset_n !== lvl && n < mx);
   endtask
   task automatic fault(logic [7:0] a, logic [7:0] bad, int b,
                        logic [7:0] por, logic [7:0] m);
      wr(OFF_FAULT_DLY, 32'h8);
      wr(a, {24'h0, bad});
      wait_rst(1'b0, 40);
      chk("fault delay", 1, n >= 8 && n <= 12);
      wait_rst(1'b1, 100);
      rd(OFF_CAUSE);
      chk("fault flag", 32'h1 << b, d);
      rd(a);
      chk("restored", {24'h0, por & m}, {24'h0, d[7:0] & m});
      wr(OFF_CAUSE, 32'hff);
      rd(OFF_CAUSE);
      chk("flag kept", 32'h1 << b, d);
      wr(OFF_CAUSE, 32'h0);
      rd(OFF_CAUSE);
      chk("flag clear", 0, d);
   endtask
   task end_of_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200us;
      err_count++;
      end_of_test();
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("por", 1, por_reset_n);
      rd(OFF_PIN_SEL);
      chk("pin por", {24'h0, PIN_SEL_POR}, d);
      rd(OFF_BO_LEVEL);
      chk("level por", {24'h0, BO_LEVEL_POR}, d);
      rd(OFF_CAUSE);
      chk("cause por", 0, d);
      rd(8'h3c);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      wr(OFF_STATUS, 32'h1);
      chk("status ro", {30'h0, RESP_SLVERR}, {30'h0, r});
      foreach (codes[i]) begin
         wr(OFF_BO_LEVEL, {24'h0, codes[i]});
         rd(OFF_BO_LEVEL);
         chk("level", {24'h0, codes[i]}, d);
         wait_rst(1'b0, 20);
         chk("level ok", 20, n);
      end
      sup_low <= 1'b1;
      wait_rst(1'b0, 40);
      chk("bo off", 40, n);
      sup_low <= 1'b0;
      wr(OFF_BO_LEVEL, {24'h0, BO_2V55});
      for (int i = 0; i < 2; i++) begin
         wr(OFF_CTRL, 32'h1 << i);
         sup_low <= 1'b1;
         wait_rst(1'b0, 40);
         chk("low power", 40, n);
         sup_low <= 1'b0;
         wr(OFF_CTRL, 32'h0);
      end
      sup_low <= 1'b1;
      repeat (6) @(posedge aclk);
      sup_low <= 1'b0;
      wait_rst(1'b0, 30);
      chk("short dip", 30, n);
      sup_low <= 1'b1;
      wait_rst(1'b0, 40);
      chk("filter", 1, n >= 12 && n <= 18);
      sup_low <= 1'b0;
      wait_rst(1'b1, 100);
      rd(OFF_BO_LEVEL);
      chk("level kept", {24'h0, BO_2V55}, d);
      rd(OFF_CAUSE);
      chk("bo flag", 32'h1 << CF_BO_EVT, d);
      wr(OFF_CAUSE, 32'h0);
      fault(OFF_PIN_SEL, 8'h12, CF_SEL, PIN_SEL_POR, 8'hff);
      fault(OFF_BO_LEVEL, 8'h12, CF_BO_SET, BO_LEVEL_POR, 8'hff);
      fault(OFF_WDT_EN, 8'h00, CF_WDT, {WDT_EN_POR, 3'b0}, 8'hf8);
      wr(OFF_FLASH_CMD, 32'h54);
      wait_rst(1'b0, 20);
      chk("flash other", 20, n);
      wr(OFF_FLASH_CMD, {24'h0, FLASH_RST_CMD});
      wait_rst(1'b0, 6);
      chk("flash", 1, n <= 4);
      wait_rst(1'b1, 100);
      wr(OFF_PIN_SEL, {24'h0, PIN_RESET});
      alt_func_req <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("pin rst", 1, pin_is_reset);
      chk("alt gated", 0, alt_func_en);
      chk("gpio rst", 1, gpio_pin_in);
      pin_low <= 1'b1;
      wait_rst(1'b0, 10);
      chk("pin assert", 1, n <= 4);
      repeat (10) @(posedge aclk);
      chk("pin hold", 0, device_reset_n);
      pin_low <= 1'b0;
      wait_rst(1'b1, 60);
      chk("release", 1, n >= 20 && n <= 26);
      chk("no por", 1, por_reset_n);
      wr(OFF_PIN_SEL, {24'h0, PIN_GPIO});
      pin_low <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("alt on", 1, alt_func_en);
      chk("gpio in", 0, gpio_pin_in);
      chk("gpio no rst", 1, device_reset_n);
      pin_low <= 1'b0;
      end_of_test();
   end
endmodule
`default_nettype wire
